//--- rtl/clk_route_pkg.sv
// Package with register map, reset values and field layout of the clock routing block
`default_nettype none
package clk_route_pkg;
    // Register offsets on the serial control port
    localparam logic [9:0] OFF_LOOP_CTRL = 10'h010;
    localparam logic [9:0] OFF_PRESCALE = 10'h1e0;
    localparam logic [9:0] OFF_ROUTING = 10'h1e1;
    localparam logic [9:0] OFF_TRANSFER = 10'h232;
    // Field positions
    localparam int POS_POLARITY = 7;
    localparam int POS_BYPASS = 0;
    localparam int POS_SOURCE = 1;
    localparam int POS_STROBE = 0;
    // Loop power field encodings
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_ASYNC_DOWN = 2'h1;
    // Values after reset
    localparam logic [7:0] RST_LOOP_CTRL = 8'h01;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    // Prescaler ratio codes
    localparam logic [2:0] RATIO_DIV2 = 3'h0;
    localparam logic [2:0] RATIO_DIV3 = 3'h1;
    localparam logic [2:0] RATIO_DIV4 = 3'h2;
    localparam logic [2:0] RATIO_DIV5 = 3'h3;
    localparam logic [2:0] RATIO_DIV6 = 3'h4;
    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

//--- rtl/div_ctrl_if.sv
// Interface joining the routing logic to the prescaling divider
`default_nettype none
interface div_ctrl_if;
    logic [2:0] ratio_code; // Selected prescaler ratio code
    logic src_edge; // One-cycle pulse per selected source edge
    logic div_tick; // One-cycle pulse per divided period
    modport ctrl (output ratio_code, output src_edge, input div_tick);
    modport div (input ratio_code, input src_edge, output div_tick);
endinterface
`default_nettype wire

//--- rtl/prescale_divider.sv
// Prescaling divider counting source edges, ratio one through six
`default_nettype none
module prescale_divider
    import clk_route_pkg::*;
#(
    parameter int CNT_W = 3
) (
    input wire logic clk_sys,
    input wire logic rst,
    div_ctrl_if.div dbus
);
    logic [CNT_W-1:0] cnt_q; // Edges seen in the current period
    logic [CNT_W-1:0] last_d; // Terminal count for the ratio
    logic tick_q; // Registered divided pulse

    // Ratio code to terminal count; spare codes give divide by one
    always_comb begin
        case (dbus.ratio_code)
            RATIO_DIV2: last_d = CNT_W'(1);
            RATIO_DIV3: last_d = CNT_W'(2);
            RATIO_DIV4: last_d = CNT_W'(3);
            RATIO_DIV5: last_d = CNT_W'(4);
            RATIO_DIV6: last_d = CNT_W'(5);
            default: last_d = '0;
        endcase
    end

    // Edge counter; a ratio cut below the count ends the period at the next source edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (dbus.src_edge) begin
            if (cnt_q >= last_d) begin
                cnt_q <= '0;
                tick_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + CNT_W'(1);
                tick_q <= 1'b0;
            end
        end else begin
            tick_q <= 1'b0;
        end
    end

    assign dbus.div_tick = tick_q;

    // Period length stays within one to six edges
    a_ratio_range: assert property (@(posedge clk_sys) disable iff (rst)
        cnt_q <= CNT_W'(5))
        else $error("prescaler count out of range");

    // Every tick is preceded by a source edge
    a_tick_cause: assert property (@(posedge clk_sys) disable iff (rst)
        tick_q |-> $past(dbus.src_edge))
        else $error("divider tick without source edge");
endmodule // prescale_divider
`default_nettype wire

//--- rtl/clock_source_routing_config.sv
// Clock source routing, prescaler and loop power configuration
// What this block does
// - Power field 01b powers the loop down
// - Power field 00b runs the loop normally
// - Routing bit 0 bypasses or uses prescaler
// - Routing bit 1 low selects external input
// - Routing bit 1 high selects internal oscillator
// - Control bit 7 sets detector polarity
// - Reset gives loop off, divide two, external
// - Prescaler divides by one through six
// - External source keeps internal oscillator off
// - Transfer strobe applies staged settings
`default_nettype none
module clock_source_routing_config
    import clk_route_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire logic ext_clk_in,
    input wire logic osc_clk_in,
    output logic loop_enable,
    output logic loop_powerdown,
    output logic osc_enable,
    output logic detector_negative,
    output logic source_internal,
    output logic dist_bypass,
    output logic loop_feed_tick,
    output logic dist_tick
);
    div_ctrl_if dbus (); // Link to the prescaling divider

    logic [7:0] loop_power_polarity_control_q; // Staged loop control
    logic [7:0] prescaler_ratio_select_q; // Staged ratio
    logic [7:0] distribution_source_routing_q; // Staged routing
    logic [7:0] act_loop_q; // Applied loop control
    logic [7:0] act_ratio_q; // Applied ratio
    logic [7:0] act_route_q; // Applied routing
    logic [7:0] rdata_q; // Registered read data
    logic xfer_strobe; // Transfer strobe write
    logic [1:0] pin_level; // Accepted pin levels, ext then osc
    logic [1:0] pin_prev_q; // Levels one cycle ago
    logic [1:0] pin_rise; // Rising edge per pin
    logic dist_tick_q; // Registered distribution pulse
    logic feed_tick_q; // Registered loop feed pulse

    // Strobe is a write of one to the transfer register
    assign xfer_strobe = reg_wr && (reg_addr == OFF_TRANSFER) && reg_wdata[POS_STROBE];

    // Staged registers take software writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            loop_power_polarity_control_q <= RST_LOOP_CTRL;
            prescaler_ratio_select_q <= RST_PRESCALE;
            distribution_source_routing_q <= RST_ROUTING;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_LOOP_CTRL: loop_power_polarity_control_q <= reg_wdata;
                OFF_PRESCALE: prescaler_ratio_select_q <= reg_wdata;
                OFF_ROUTING: distribution_source_routing_q <= reg_wdata;
                default: ; // Unmapped writes are dropped
            endcase
        end
    end

    // Applied copies change only on the transfer strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            act_loop_q <= RST_LOOP_CTRL;
            act_ratio_q <= RST_PRESCALE;
            act_route_q <= RST_ROUTING;
        end else if (xfer_strobe) begin
            act_loop_q <= loop_power_polarity_control_q;
            act_ratio_q <= prescaler_ratio_select_q;
            act_route_q <= distribution_source_routing_q;
        end
    end

    // Readback of staged values; unmapped addresses read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            case (reg_addr)
                OFF_LOOP_CTRL: rdata_q <= loop_power_polarity_control_q;
                OFF_PRESCALE: rdata_q <= prescaler_ratio_select_q;
                OFF_ROUTING: rdata_q <= distribution_source_routing_q;
                default: rdata_q <= 8'h00; // Strobe register is write-only
            endcase
        end
    end
    assign reg_rdata = rdata_q;

    // Loop power decode; only 00b runs the loop, all else is off
    assign loop_enable = (act_loop_q[1:0] == PWR_NORMAL);
    assign loop_powerdown = !loop_enable;
    assign detector_negative = act_loop_q[POS_POLARITY];
    assign source_internal = act_route_q[POS_SOURCE];
    assign dist_bypass = act_route_q[POS_BYPASS];
    // Oscillator runs only for the loop with the internal source
    assign osc_enable = loop_enable && source_internal;

    // Pin synchronisers; stage 1 feeds only stage 2
    for (genvar p = 0; p < 2; p++) begin : g_pin
        logic [SYNC_STAGES-1:0] sync_q; // Shift chain
        logic level_q; // Accepted level
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                sync_q <= '0;
            end else begin
                sync_q <= {sync_q[SYNC_STAGES-2:0], (p == 0) ? ext_clk_in : osc_clk_in};
            end
        end
        // Level changes only once stages two and three agree
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                level_q <= 1'b0;
            end else if (sync_q[1] == sync_q[2]) begin
                level_q <= sync_q[2];
            end
        end
        assign pin_level[p] = level_q;
    end

    // Previous levels for edge detection
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_prev_q <= 2'h0;
        end else begin
            pin_prev_q <= pin_level;
        end
    end
    assign pin_rise = pin_level & ~pin_prev_q;

    // Source select feeds the divider
    assign dbus.src_edge = source_internal ? pin_rise[1] : pin_rise[0];
    assign dbus.ratio_code = act_ratio_q[2:0];

    prescale_divider #(.CNT_W(3)) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .dbus(dbus)
    );

    // Distribution pulse; bypass passes each source edge straight on
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dist_tick_q <= 1'b0;
        end else begin
            dist_tick_q <= dist_bypass ? dbus.src_edge : dbus.div_tick;
        end
    end
    assign dist_tick = dist_tick_q;

    // External input goes straight to the loop prescaler when loop runs with the external source selected
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            feed_tick_q <= 1'b0;
        end else begin
            feed_tick_q <= loop_enable && !source_internal && pin_rise[0];
        end
    end
    assign loop_feed_tick = feed_tick_q;

    // Loop never runs on a power code other than 00b
    a_loop_off_codes: assert property (@(posedge clk_sys) disable iff (rst)
        (act_loop_q[1:0] != PWR_NORMAL) |-> (loop_powerdown && !loop_enable && !osc_enable))
        else $error("loop enabled on a power-down code");

    // Strobe applies the staged power field one cycle later
    a_strobe_apply: assert property (@(posedge clk_sys) disable iff (rst)
        xfer_strobe |=> (loop_enable == ($past(loop_power_polarity_control_q[1:0]) == 2'h0)))
        else $error("transfer strobe did not apply power field");

    // Without a strobe the applied routing holds
    a_hold_no_strobe: assert property (@(posedge clk_sys) disable iff (rst)
        !xfer_strobe |=> $stable(act_route_q) && $stable(act_ratio_q))
        else $error("applied settings changed without strobe");

    // Polarity follows staged bit after strobe
    a_polarity_apply: assert property (@(posedge clk_sys) disable iff (rst)
        xfer_strobe |=> detector_negative == $past(loop_power_polarity_control_q[7]))
        else $error("detector polarity not applied");

    // First cycle after reset shows the defaults
    a_reset_defaults: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rst) |-> (loop_powerdown && !dist_bypass && !source_internal
            && act_ratio_q[2:0] == 3'h0))
        else $error("reset defaults wrong");

    // Bypass forwards every source edge next cycle
    a_bypass_path: assert property (@(posedge clk_sys) disable iff (rst)
        (dist_bypass && dbus.src_edge) |=> dist_tick)
        else $error("bypass did not pass source edge");

    // External source edge with loop on feeds the loop next cycle
    a_ext_feed: assert property (@(posedge clk_sys) disable iff (rst)
        (loop_enable && !source_internal && pin_rise[0]) |=> loop_feed_tick)
        else $error("external feed to loop wrong");

    // Internal source selection takes the oscillator pin
    a_source_select: assert property (@(posedge clk_sys) disable iff (rst)
        dbus.src_edge |-> (source_internal ? $rose(pin_level[1]) : $rose(pin_level[0])))
        else $error("wrong source edge selected");

    // Oscillator stays off whenever the external pin is the source
    a_osc_ext_off: assert property (@(posedge clk_sys) disable iff (rst)
        !source_internal |-> !osc_enable)
        else $error("oscillator on with external source");

    // Without bypass the distribution pulse is the divided pulse
    a_divided_path: assert property (@(posedge clk_sys) disable iff (rst)
        !dist_bypass |=> (dist_tick == $past(dbus.div_tick)))
        else $error("divided path not used without bypass");

    // Asynchronous power-down code keeps the loop off
    a_power_decode: assert property (@(posedge clk_sys) disable iff (rst)
        (act_loop_q[1:0] == PWR_ASYNC_DOWN) |-> (loop_powerdown && !loop_enable))
        else $error("loop running on power-down code");
endmodule // clock_source_routing_config
`default_nettype wire

//--- test/clk_source_model.sv
// Behavioural far side: external clock source and internal oscillator stand-in
`default_nettype none
module clk_source_model (
    input wire logic clk_sys,
    input wire logic [3:0] ext_half,
    input wire logic [3:0] osc_half,
    output logic ext_clk_in,
    output logic osc_clk_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int ext_cnt = 0; // Cycles spent in current external level
    int osc_cnt = 0; // Cycles spent in current oscillator level
    logic ext_q = 1'b0; // External pin level, idles low
    logic osc_q = 1'b0; // Oscillator pin level, idles low
    // Toggle on falling edges; half period kept at 3 or more so no level is lost
    always @(negedge clk_sys) begin
        ext_cnt = ext_cnt + 1;
        osc_cnt = osc_cnt + 1;
        if (ext_cnt >= ext_half) begin
            ext_q <= ~ext_q;
            ext_cnt = 0;
        end
        if (osc_cnt >= osc_half) begin
            osc_q <= ~osc_q;
            osc_cnt = 0;
        end
    end
    // One driver per pin
    assign ext_clk_in = ext_q;
    assign osc_clk_in = osc_q;
endmodule // clk_source_model
`default_nettype wire

//--- test/clock_source_routing_config_tb_top.sv
// Self-checking bench for the clock routing configuration block
`default_nettype none
module clock_source_routing_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_route_pkg::*;
    logic clk_sys = 1'b0; // 50 MHz system clock
    logic rst = 1'b1; // Async reset, high
    logic [9:0] reg_addr = 10'h000; // Register port
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_rdata;
    logic ext_clk_in, osc_clk_in, loop_enable, loop_powerdown, osc_enable;
    logic detector_negative, source_internal, dist_bypass, loop_feed_tick, dist_tick;
    logic [3:0] ext_half = 4'h3; // Source half periods in clk_sys cycles
    logic [3:0] osc_half = 4'h4;
    int n_fail = 0;
    int checks = 0;
    int n, h, c;
    clock_source_routing_config uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in), .loop_enable(loop_enable),
        .loop_powerdown(loop_powerdown), .osc_enable(osc_enable),
        .detector_negative(detector_negative), .source_internal(source_internal),
        .dist_bypass(dist_bypass), .loop_feed_tick(loop_feed_tick), .dist_tick(dist_tick));
    clk_source_model src (.clk_sys(clk_sys), .ext_half(ext_half), .osc_half(osc_half),
        .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in));
    always #10 clk_sys = ~clk_sys;
    // Applied routing flags packed into one byte for comparison
    function automatic logic [7:0] flags();
        return {2'h0, loop_enable, loop_powerdown, osc_enable, detector_negative,
            source_internal, dist_bypass};
    endfunction
    // Expected divide ratio of a prescaler code
    function automatic int ratio(int code);
        return (code <= 4) ? code + 2 : 1;
    endfunction
    // Compare a design byte
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compare a measured tick spacing
    task automatic chk_gap(int got, int exp);
        checks++;
        if (got != exp) begin
            n_fail++;
            $display("wrong value at %0t: tick gap %0d expected %0d", $time, got, exp);
        end
    endtask
    // One-cycle write pulse, driven on the falling edge
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    // Readback one cycle after the address is presented
    task automatic rd(logic [9:0] a, logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    // Spacing of ticks; early gaps skipped, the divider count may be stale
    task automatic gap(bit feed, output int len);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            len = 1;
            while ((feed ? loop_feed_tick : dist_tick) !== 1'b1 && len < 400) begin
                @(negedge clk_sys);
                len++;
            end
        end
    endtask
    // Reset pulse of five cycles, then check defaults
    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        chk(flags(), 8'h10);
        rd(OFF_LOOP_CTRL, 8'h01);
        rd(OFF_PRESCALE, 8'h00);
        rd(OFF_ROUTING, 8'h00);
    endtask
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog, well beyond the thousand or so cycles the sequence needs
    initial begin
        #400us;
        n_fail++;
        wrap_up();
    end
    initial begin
        c = $urandom(59346);
        do_reset();
        gap(0, n);
        chk_gap(n, 2 * 2 * 3);
        // Loop on, negative detector polarity, external source feeds the loop; staged until strobe
        wr(OFF_LOOP_CTRL, 8'h80);
        chk(flags(), 8'h10);
        wr(OFF_TRANSFER, 8'h01);
        chk(flags(), 8'h24);
        gap(1, n);
        chk_gap(n, 2 * 3);
        // Every power code, polarity positive
        for (int p = 0; p < 4; p++) begin
            wr(OFF_LOOP_CTRL, p[7:0]);
            wr(OFF_TRANSFER, 8'h01);
            chk(flags(), (p == 0) ? 8'h20 : 8'h10);
        end
        // Every ratio code with a random source period
        for (int r = 0; r < 8; r++) begin
            h = $urandom_range(5, 3);
            ext_half = h[3:0];
            wr(OFF_PRESCALE, r[7:0]);
            wr(OFF_TRANSFER, 8'h01);
            rd(OFF_PRESCALE, r[7:0]);
            gap(0, n);
            chk_gap(n, ratio(r) * 2 * h);
        end
        // Bypass with the external source, prescaler code 4 ignored
        wr(OFF_PRESCALE, 8'h04);
        wr(OFF_ROUTING, 8'h01);
        wr(OFF_TRANSFER, 8'h01);
        gap(0, n);
        chk_gap(n, 2 * h);
        // Internal oscillator with loop on
        wr(OFF_LOOP_CTRL, 8'h00);
        wr(OFF_ROUTING, 8'h03);
        wr(OFF_TRANSFER, 8'h01);
        chk(flags(), 8'h2b);
        gap(0, n);
        chk_gap(n, 2 * 4);
        // Strobe register written with bit 0 low applies nothing
        wr(OFF_LOOP_CTRL, 8'h01);
        wr(OFF_TRANSFER, 8'h00);
        chk(flags(), 8'h2b);
        // Unmapped place and strobe register read zero
        wr(10'h3ff, 8'hff);
        rd(10'h3ff, 8'h00);
        rd(OFF_ROUTING, 8'h03);
        rd(OFF_LOOP_CTRL, 8'h01);
        rd(OFF_TRANSFER, 8'h00);
        do_reset();
        wrap_up();
    end
endmodule // clock_source_routing_config_tb_top
`default_nettype wire
